// ===== indexed_seq_params.svh
// constants for the indexed mode bus sequencer
`ifndef INDEXED_SEQ_PARAMS_SVH
`define INDEXED_SEQ_PARAMS_SVH

// cycles spent per instruction group
`define IMS_LEN_JUMP     4'h4
`define IMS_LEN_ACC_READ 4'h5
`define IMS_LEN_WIDE_LD  4'h6
`define IMS_LEN_ACC_ST   4'h6
`define IMS_LEN_RMW      4'h7
`define IMS_LEN_WIDE_ST  4'h7
`define IMS_LEN_CALL     4'h8

// cycle numbers within an instruction
`define IMS_CYC_FETCH    4'h1
`define IMS_CYC_OFFSET   4'h2
`define IMS_CYC_INDEX    4'h3
`define IMS_CYC_NOCARRY  4'h4
`define IMS_CYC_FIVE     4'h5
`define IMS_CYC_SIX      4'h6
`define IMS_CYC_SEVEN    4'h7
`define IMS_CYC_EIGHT    4'h8

// reset values of the pointers
`define IMS_PC_RST       16'h0000
`define IMS_IX_RST       16'h0000
`define IMS_SP_RST       16'h0000

// address steps
`define IMS_INSTR_LEN    16'h0002
`define IMS_ONE          16'h0001
`define IMS_TWO          16'h0002

`endif

// ===== indexed_seq_pkg.sv
// types shared by the indexed mode bus sequencer
package indexed_seq_pkg;

	// instruction groups of the indexed mode
	typedef enum logic [3:0] {
		GRP_JUMP,
		GRP_ACC_READ,
		GRP_WIDE_LOAD,
		GRP_ACC_STORE,
		GRP_RMW,
		GRP_TEST,
		GRP_STORE_SP,
		GRP_STORE_IX,
		GRP_CALL
	} op_group_t;

	// sequencer phase
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RUN
	} seq_state_t;

	// all state of the sequencer
	typedef struct packed {
		seq_state_t  st;       // idle or running
		logic [3:0]  cyc;      // current cycle number
		op_group_t   grp;      // group in flight
		logic [15:0] pc;       // program counter
		logic [15:0] ix;       // index pointer
		logic [15:0] sp;       // stack pointer
		logic [15:0] opaddr;   // opcode address of current instruction
		logic [7:0]  off;      // unsigned offset byte
		logic [7:0]  acc;      // accumulator value to store
		logic [7:0]  hi_buf;   // high byte of a wide read
		logic [15:0] addr;     // address bus
		logic        valid_address_qualifier;      // valid address qualifier
		logic        rw;       // read high, write low
		logic [7:0]  dout;     // data bus out
		logic        doe;      // data bus drive enable
		logic [15:0] operand;  // operand read from memory
		logic        opv;      // operand valid pulse
	} seq_regs_t;

endpackage

// ===== indexed_ea_unit.sv
// effective address arithmetic for indexed mode
`timescale 1ns/1ps
`default_nettype none
`include "indexed_seq_params.svh"

module indexed_ea_unit (
	// operands
	input  wire logic [15:0] i_index,
	input  wire logic [7:0]  i_offset,
	// results
	output logic      [15:0] o_sum_nocarry,
	output logic      [15:0] o_sum,
	output logic      [15:0] o_sum_plus1
);
	logic [8:0] low_sum; // low byte sum with carry out

	// unsigned offset, zero-extended; zero gives the index itself
	always_comb begin
		low_sum       = {1'b0, i_index[7:0]} + {1'b0, i_offset};
		o_sum_nocarry = {i_index[15:8], low_sum[7:0]};
		o_sum         = i_index + {8'h00, i_offset};
		o_sum_plus1   = o_sum + `IMS_ONE;
	end

endmodule

`default_nettype wire

// ===== indexed_mode_bus_sequencer.sv
// indexed addressing mode bus sequencer
// Summary of operation
// - index pointer loads, increments and decrements
// - unsigned byte offset added to index
// - cycles one, two fetch opcode, offset
// - cycle counts 4,5,6,6,7,7,8 per group
// - cycle three: index address, unqualified, reading
// - cycle four: sum without carry, unqualified, except call
// - from five carried sum except call; reads in five for read, wide load, modify, test
// - wide load: high at EA, low EA+1
// - accumulator store: idle five, write six
// - wide store: high six, low seven
// - modify: read five, idle six, write seven
// - test operand: final write cycle unqualified
// - call: push low, high, three idle cycles
// - zero offset gives index itself
`timescale 1ns/1ps
`default_nettype none
`include "indexed_seq_params.svh"

module indexed_mode_bus_sequencer (
	// clock and reset
	input  wire logic                       i_core_clk,
	input  wire logic                       i_rst_n,
	// instruction request
	input  wire logic                       i_start,
	input  wire indexed_seq_pkg::op_group_t i_group,
	input  wire logic [7:0]                 i_acc,
	input  wire logic [7:0]                 i_new_operand,
	// pointer updates
	input  wire logic                       i_ix_load,
	input  wire logic [15:0]                i_ix_value,
	input  wire logic                       i_ix_inc,
	input  wire logic                       i_ix_dec,
	input  wire logic                       i_sp_load,
	input  wire logic [15:0]                i_sp_value,
	input  wire logic                       i_pc_load,
	input  wire logic [15:0]                i_pc_value,
	// system bus
	input  wire logic [7:0]                 i_data,
	output logic      [15:0]                o_addr,
	output logic                            o_valid_address_qualifier,
	output logic                            o_rw,
	output logic      [7:0]                 o_data,
	output logic                            o_data_oe,
	// status
	output logic                            o_ready,
	output logic                            o_last,
	output logic      [15:0]                o_operand,
	output logic                            o_operand_valid,
	output logic      [15:0]                o_pc,
	output logic      [15:0]                o_index_pointer,
	output logic      [15:0]                o_stack_pointer
);
	import indexed_seq_pkg::*;

	seq_regs_t   s_q;          // registered state
	seq_regs_t   s_d;          // next state
	logic [15:0] ea_nocarry;   // index plus offset, no carry
	logic [15:0] ea_sum;       // index plus offset
	logic [15:0] ea_plus1;     // index plus offset plus one
	logic [15:0] ret_addr;     // return address for a call
	logic        last;         // final cycle of the instruction
	logic        ready;        // a new instruction may be taken
	logic [3:0]  nc;           // number of the next cycle

	// cycles spent by each group
	function automatic logic [3:0] group_len(input op_group_t g);
		case (g)
			GRP_JUMP:      group_len = `IMS_LEN_JUMP;
			GRP_ACC_READ:  group_len = `IMS_LEN_ACC_READ;
			GRP_WIDE_LOAD: group_len = `IMS_LEN_WIDE_LD;
			GRP_ACC_STORE: group_len = `IMS_LEN_ACC_ST;
			GRP_RMW:       group_len = `IMS_LEN_RMW;
			GRP_TEST:      group_len = `IMS_LEN_RMW;
			GRP_STORE_SP:  group_len = `IMS_LEN_WIDE_ST;
			GRP_STORE_IX:  group_len = `IMS_LEN_WIDE_ST;
			GRP_CALL:      group_len = `IMS_LEN_CALL;
			default:       group_len = `IMS_LEN_JUMP;
		endcase
	endfunction

	// address arithmetic
	indexed_ea_unit u_ea (
		.i_index       (s_q.ix),
		.i_offset      (s_q.off),
		.o_sum_nocarry (ea_nocarry),
		.o_sum         (ea_sum),
		.o_sum_plus1   (ea_plus1)
	);

	// next-state logic
	always_comb begin
		s_d      = s_q;
		s_d.opv  = 1'b0;
		ret_addr = s_q.opaddr + `IMS_INSTR_LEN;
		last     = (s_q.st == ST_RUN) && (s_q.cyc == group_len(s_q.grp));
		ready    = (s_q.st == ST_IDLE) || last;
		nc       = s_q.cyc + 4'h1;

		// sample the data bus at the end of read cycles
		if (s_q.st == ST_RUN) begin
			case (s_q.cyc)
				`IMS_CYC_OFFSET: begin
					s_d.off = i_data;
				end
				`IMS_CYC_FIVE: begin
					if (s_q.grp == GRP_ACC_READ || s_q.grp == GRP_RMW
							|| s_q.grp == GRP_TEST) begin
						s_d.operand = {8'h00, i_data};
						s_d.opv     = 1'b1;
					end else if (s_q.grp == GRP_WIDE_LOAD) begin
						s_d.hi_buf = i_data;
					end
				end
				`IMS_CYC_SIX: begin
					if (s_q.grp == GRP_WIDE_LOAD) begin
						s_d.operand = {s_q.hi_buf, i_data};
						s_d.opv     = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end

		// completion effects on the pointers
		if (last) begin
			case (s_q.grp)
				GRP_JUMP: begin
					s_d.pc = ea_sum;
				end
				GRP_CALL: begin
					s_d.pc = ea_sum;
					s_d.sp = s_q.sp - `IMS_TWO;
				end
				default: begin
					s_d.pc = ret_addr;
				end
			endcase
		end

		// bus defaults: unqualified read, data bus released
		s_d.valid_address_qualifier = 1'b0;
		s_d.rw  = 1'b1;
		s_d.doe = 1'b0;

		if (ready) begin
			// pointer updates from the core between instructions
			if (i_ix_load) begin
				s_d.ix = i_ix_value;
			end else if (i_ix_inc) begin
				s_d.ix = s_q.ix + `IMS_ONE;
			end else if (i_ix_dec) begin
				s_d.ix = s_q.ix - `IMS_ONE;
			end
			if (i_sp_load) begin
				s_d.sp = i_sp_value;
			end
			if (i_pc_load) begin
				s_d.pc = i_pc_value;
			end
			if (i_start) begin
				// cycle one: opcode fetch
				s_d.st     = ST_RUN;
				s_d.cyc    = `IMS_CYC_FETCH;
				s_d.grp    = i_group;
				s_d.acc    = i_acc;
				s_d.opaddr = s_d.pc;
				s_d.addr   = s_d.pc;
				s_d.valid_address_qualifier    = 1'b1;
			end else begin
				// idle: park on the program counter, unqualified
				s_d.st   = ST_IDLE;
				s_d.cyc  = 4'h0;
				s_d.addr = s_d.pc;
			end
		end else begin
			s_d.cyc = nc;
			case (nc)
				`IMS_CYC_OFFSET: begin
					s_d.addr = s_q.opaddr + `IMS_ONE;
					s_d.valid_address_qualifier  = 1'b1;
				end
				`IMS_CYC_INDEX: begin
					s_d.addr = s_q.ix;
				end
				`IMS_CYC_NOCARRY: begin
					if (s_q.grp == GRP_CALL) begin
						s_d.addr = s_q.sp;
						s_d.valid_address_qualifier  = 1'b1;
						s_d.rw   = 1'b0;
						s_d.dout = ret_addr[7:0];
						s_d.doe  = 1'b1;
					end else begin
						s_d.addr = ea_nocarry;
					end
				end
				`IMS_CYC_FIVE: begin
					s_d.addr = ea_sum;
					case (s_q.grp)
						GRP_CALL: begin
							s_d.addr = s_q.sp - `IMS_ONE;
							s_d.valid_address_qualifier  = 1'b1;
							s_d.rw   = 1'b0;
							s_d.dout = ret_addr[15:8];
							s_d.doe  = 1'b1;
						end
						GRP_ACC_READ, GRP_WIDE_LOAD, GRP_RMW, GRP_TEST: begin
							s_d.valid_address_qualifier = 1'b1;
						end
						default: begin
							s_d.valid_address_qualifier = 1'b0;
						end
					endcase
				end
				`IMS_CYC_SIX: begin
					s_d.addr = ea_sum;
					case (s_q.grp)
						GRP_CALL: begin
							s_d.addr = s_q.sp - `IMS_TWO;
						end
						GRP_WIDE_LOAD: begin
							s_d.addr = ea_plus1;
							s_d.valid_address_qualifier  = 1'b1;
						end
						GRP_ACC_STORE: begin
							s_d.valid_address_qualifier  = 1'b1;
							s_d.rw   = 1'b0;
							s_d.dout = s_q.acc;
							s_d.doe  = 1'b1;
						end
						GRP_STORE_SP, GRP_STORE_IX: begin
							s_d.valid_address_qualifier  = 1'b1;
							s_d.rw   = 1'b0;
							s_d.dout = (s_q.grp == GRP_STORE_SP) ? s_q.sp[15:8] : s_q.ix[15:8];
							s_d.doe  = 1'b1;
						end
						default: begin
							s_d.valid_address_qualifier = 1'b0;
						end
					endcase
				end
				`IMS_CYC_SEVEN: begin
					s_d.addr = ea_sum;
					case (s_q.grp)
						GRP_CALL: begin
							s_d.addr = s_q.ix;
						end
						GRP_RMW: begin
							s_d.valid_address_qualifier  = 1'b1;
							s_d.rw   = 1'b0;
							s_d.dout = i_new_operand;
							s_d.doe  = 1'b1;
						end
						GRP_TEST: begin
							s_d.rw = 1'b0;
						end
						GRP_STORE_SP, GRP_STORE_IX: begin
							s_d.addr = ea_plus1;
							s_d.valid_address_qualifier  = 1'b1;
							s_d.rw   = 1'b0;
							s_d.dout = (s_q.grp == GRP_STORE_SP) ? s_q.sp[7:0] : s_q.ix[7:0];
							s_d.doe  = 1'b1;
						end
						default: begin
						end
					endcase
				end
				`IMS_CYC_EIGHT: begin
					s_d.addr = s_q.ix;
				end
				default: begin
				end
			endcase
		end
	end

	// state register
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			s_q         <= '0;
			s_q.st      <= ST_IDLE;
			s_q.grp     <= GRP_JUMP;
			s_q.pc      <= `IMS_PC_RST;
			s_q.ix      <= `IMS_IX_RST;
			s_q.sp      <= `IMS_SP_RST;
			s_q.addr    <= `IMS_PC_RST;
			s_q.rw      <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs
	assign o_addr                    = s_q.addr;
	assign o_valid_address_qualifier = s_q.valid_address_qualifier;
	assign o_rw                      = s_q.rw;
	assign o_data                    = s_q.dout;
	assign o_data_oe                 = s_q.doe;
	assign o_ready                   = ready;
	assign o_last                    = last;
	assign o_operand                 = s_q.operand;
	assign o_operand_valid           = s_q.opv;
	assign o_pc                      = s_q.pc;
	assign o_index_pointer           = s_q.ix;
	assign o_stack_pointer           = s_q.sp;

endmodule

`default_nettype wire

// ===== ims_checker.sv
// assertions for the indexed mode bus sequencer
`timescale 1ns/1ps
`default_nettype none
`include "indexed_seq_params.svh"
module ims_checker
	import indexed_seq_pkg::*;
(
	// clock and request
	input wire logic             i_core_clk,
	input wire logic             i_rst_n,
	input wire logic             i_start,
	input wire op_group_t        i_group,
	input wire logic [7:0]       i_acc,
	input wire logic [7:0]       i_data,
	// bus and status
	input wire logic [15:0]      o_addr,
	input wire logic             o_valid_address_qualifier,
	input wire logic             o_rw,
	input wire logic [7:0]       o_data,
	input wire logic             o_data_oe,
	input wire logic             o_ready,
	input wire logic             o_last,
	input wire logic [15:0]      o_pc,
	input wire logic [15:0]      o_index_pointer,
	input wire logic [15:0]      o_stack_pointer
);
	wire        valid_address_qualifier = o_valid_address_qualifier; // short alias
	wire        take = o_ready && i_start;       // request accepted
	logic       run_q;                           // instruction in flight
	logic [3:0] cnt_q;                           // cycle number
	op_group_t  grp_q;                           // group in flight
	logic [3:0] len;                             // expected length
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	// length of the group in flight
	always_comb begin
		case (grp_q)
			GRP_JUMP: len = `IMS_LEN_JUMP;
			GRP_ACC_READ: len = `IMS_LEN_ACC_READ;
			GRP_WIDE_LOAD: len = `IMS_LEN_WIDE_LD;
			GRP_ACC_STORE: len = `IMS_LEN_ACC_ST;
			GRP_CALL: len = `IMS_LEN_CALL;
			default: len = `IMS_LEN_RMW;
		endcase
	end
	// count cycles since the take edge
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			run_q <= 1'b0;
			cnt_q <= 4'h0;
			grp_q <= GRP_JUMP;
		end else if (take) begin
			run_q <= 1'b1;
			cnt_q <= 4'h1;
			grp_q <= i_group;
		end else if (o_last) begin
			run_q <= 1'b0;
		end else if (run_q) begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
	property p_nc;
		logic [7:0] o;
		(take && i_group != GRP_CALL) ##2 (1'b1, o = i_data) |-> ##2 (!valid_address_qualifier &&
			o_addr == {o_index_pointer[15:8], o_index_pointer[7:0] + o});
	endproperty
	property p_rd;
		logic [7:0] o;
		(take && i_group == GRP_ACC_READ) ##2 (1'b1, o = i_data) |-> ##3
			(valid_address_qualifier && o_rw && o_addr == o_index_pointer + {8'h00, o});
	endproperty
	property p_jmp;
		logic [7:0] o;
		(take && i_group == GRP_JUMP) ##2 (1'b1, o = i_data) |-> ##3
			(o_pc == o_index_pointer + {8'h00, o});
	endproperty
	a_len_exact: assert property (o_last == (run_q && cnt_q == len))
		else $error("instruction length wrong");
	a_fetch_pair: assert property (take |=> valid_address_qualifier && o_rw ##1
		valid_address_qualifier && o_rw && o_addr == $past(o_addr) + 16'h0001) else $error("fetch wrong");
	a_index_cycle: assert property (take |-> ##3
		!valid_address_qualifier && o_rw && o_addr == o_index_pointer) else $error("cycle three wrong");
	a_nocarry_sum: assert property (p_nc) else $error("cycle four wrong");
	a_carry_read: assert property (p_rd) else $error("operand read wrong");
	a_jump_target: assert property (p_jmp) else $error("jump target wrong");
	a_acc_store: assert property ((take && i_group == GRP_ACC_STORE) |-> ##5 !valid_address_qualifier
		##1 (valid_address_qualifier && !o_rw && o_data_oe && o_data == $past(i_acc, 6)))
		else $error("store wrong");
	a_rmw_order: assert property ((take && i_group == GRP_RMW) |-> ##5
		(valid_address_qualifier && o_rw) ##1 (!valid_address_qualifier && o_rw) ##1 (valid_address_qualifier && !o_rw && o_data_oe))
		else $error("modify order wrong");
	a_test_quiet: assert property ((take && i_group == GRP_TEST) |-> ##7
		(!valid_address_qualifier && !o_data_oe)) else $error("test wrote");
	a_call_push: assert property ((take && i_group == GRP_CALL) |-> ##4
		(valid_address_qualifier && !o_rw && o_addr == o_stack_pointer) ##1 (valid_address_qualifier && !o_rw &&
		o_addr == o_stack_pointer - 16'h0001) ##1 (!valid_address_qualifier [*3])) else $error("call wrong");
	a_wide_store: assert property ((take && i_group == GRP_STORE_IX) |-> ##6
		(valid_address_qualifier && !o_rw && o_data == o_index_pointer[15:8]) ##1 (valid_address_qualifier && !o_rw &&
		o_data == o_index_pointer[7:0] && o_addr == $past(o_addr) + 16'h0001))
		else $error("wide store wrong");
	c_call: cover property (take && i_group == GRP_CALL);
	c_rmw: cover property (take && i_group == GRP_RMW);
	c_wide: cover property (take && i_group == GRP_WIDE_LOAD);
endmodule
bind indexed_mode_bus_sequencer ims_checker u_ims_checker (.i_core_clk, .i_rst_n,
	.i_start, .i_group, .i_acc, .i_data, .o_addr, .o_valid_address_qualifier, .o_rw,
	.o_data, .o_data_oe, .o_ready, .o_last, .o_pc, .o_index_pointer, .o_stack_pointer);
`default_nettype wire

// ===== ims_mem_model.sv
// memory and peripheral model on the shared bus
`timescale 1ns/1ps
`default_nettype none
module ims_mem_model (
	// bus from the sequencer
	input  wire logic        i_clk,
	input  wire logic [15:0] i_addr,
	input  wire logic        i_vma,
	input  wire logic        i_rw,
	input  wire logic [7:0]  i_wdata,
	// read data back
	output logic      [7:0]  o_rdata
);
	logic [7:0] mem [0:65535];  // flat byte store
	logic [7:0] last_q = 8'h00; // last bus value
	// drive only qualified reads, otherwise a changing junk pattern
	assign o_rdata = (i_vma && i_rw) ? mem[i_addr] : ~last_q;
	// qualified writes land, history feeds the float pattern
	always @(posedge i_clk) begin
		last_q <= o_rdata;
		if (i_vma && !i_rw) begin
			mem[i_addr] <= i_wdata;
		end
	end
endmodule
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the indexed mode bus sequencer
`timescale 1ns/1ps
`default_nettype none
`include "indexed_seq_params.svh"
module tb_top;
	import indexed_seq_pkg::*;
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        start = 1'b0;
	op_group_t   grp = GRP_JUMP;
	logic [7:0]  acc = 8'h00;
	logic [7:0]  nop = 8'h00;
	logic        ix_ld = 1'b0;
	logic        ix_inc = 1'b0;
	logic        ix_dec = 1'b0;
	logic        sp_ld = 1'b0;
	logic        pc_ld = 1'b0;
	logic [15:0] ld_v = 16'h0000;
	logic [7:0]  rdata, wdata;
	logic [15:0] addr, operand, pc, ix, sp;
	logic        valid_address_qualifier, rw, last, ready, opv;
	logic [15:0] n_opv = 16'h0000;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	always #20 core_clk = ~core_clk;
	indexed_mode_bus_sequencer u_indexed_mode_bus_sequencer (.i_core_clk(core_clk),
		.i_rst_n(rst_n), .i_start(start), .i_group(grp), .i_acc(acc),
		.i_new_operand(nop), .i_ix_load(ix_ld), .i_ix_value(ld_v), .i_ix_inc(ix_inc),
		.i_ix_dec(ix_dec), .i_sp_load(sp_ld), .i_sp_value(ld_v), .i_pc_load(pc_ld),
		.i_pc_value(ld_v), .i_data(rdata), .o_addr(addr),
		.o_valid_address_qualifier(valid_address_qualifier), .o_rw(rw), .o_data(wdata), .o_data_oe(),
		.o_ready(ready), .o_last(last), .o_operand(operand), .o_operand_valid(opv),
		.o_pc(pc), .o_index_pointer(ix), .o_stack_pointer(sp));
	ims_mem_model u_ims_mem_model (.i_clk(core_clk), .i_addr(addr), .i_vma(valid_address_qualifier),
		.i_rw(rw), .i_wdata(wdata), .o_rdata(rdata));
	// compare one value
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	// byte of the memory model, widened
	function automatic logic [15:0] m(input logic [15:0] a);
		return {8'h00, u_ims_mem_model.mem[a]};
	endfunction
	// two bytes of the memory model, lower address in the high byte
	function automatic logic [15:0] m2(input logic [15:0] a);
		return {u_ims_mem_model.mem[a], u_ims_mem_model.mem[a + 16'h0001]};
	endfunction
	// expected cycle count of a group
	function automatic logic [3:0] glen(input op_group_t g);
		case (g)
			GRP_JUMP:      return `IMS_LEN_JUMP;
			GRP_ACC_READ:  return `IMS_LEN_ACC_READ;
			GRP_WIDE_LOAD: return `IMS_LEN_WIDE_LD;
			GRP_ACC_STORE: return `IMS_LEN_ACC_ST;
			GRP_STORE_SP,
			GRP_STORE_IX:  return `IMS_LEN_WIDE_ST;
			GRP_CALL:      return `IMS_LEN_CALL;
			default:       return `IMS_LEN_RMW;
		endcase
	endfunction
	// load one pointer while idle: 0 index, 1 stack, 2 program counter
	task automatic ld(input logic [1:0] k, input logic [15:0] v);
		@(posedge core_clk);
		ix_ld <= (k == 2'h0);
		sp_ld <= (k == 2'h1);
		pc_ld <= (k == 2'h2);
		ld_v <= v;
		@(posedge core_clk);
		{ix_ld, sp_ld, pc_ld} <= 3'h0;
	endtask
	// run one instruction, offset placed after the opcode
	task automatic exec(input op_group_t g, input logic [7:0] off, a, n);
		int k;
		@(negedge core_clk);
		u_ims_mem_model.mem[pc + 16'h0001] = off;
		chk({15'h0000, ready}, 16'h0001);
		n_opv = 16'h0000;
		@(posedge core_clk);
		start <= 1'b1;
		grp <= g;
		acc <= a;
		nop <= n;
		@(posedge core_clk);
		start <= 1'b0;
		k = 0;
		do begin
			@(negedge core_clk);
			k++;
			n_opv = n_opv + {15'h0000, opv};
		end while (last !== 1'b1 && k < 20);
		chk(k[15:0], {12'h000, glen(g)});
		repeat (2) begin
			@(negedge core_clk);
			n_opv = n_opv + {15'h0000, opv};
		end
	endtask
	// index pointer load, increment, decrement twice
	task automatic t_ptr();
		ld(2'h0, 16'h1234);
		@(posedge core_clk);
		ix_inc <= 1'b1;
		@(posedge core_clk);
		ix_inc <= 1'b0;
		ix_dec <= 1'b1;
		repeat (2) @(posedge core_clk);
		ix_dec <= 1'b0;
		@(negedge core_clk);
		chk(ix, 16'h1233);
	endtask
	// byte reads with carry, zero and largest offset
	task automatic t_read();
		ld(2'h2, 16'h0100);
		ld(2'h0, 16'h00f0);
		u_ims_mem_model.mem[16'h0110] = 8'ha5;
		u_ims_mem_model.mem[16'h00f0] = 8'h5a;
		u_ims_mem_model.mem[16'h01ef] = 8'hc3;
		exec(GRP_ACC_READ, 8'h20, 8'h00, 8'h00);
		chk(operand, 16'h00a5);
		chk(n_opv, 16'h0001);
		chk(pc, 16'h0102);
		exec(GRP_ACC_READ, 8'h00, 8'h00, 8'h00);
		chk(operand, 16'h005a);
		exec(GRP_ACC_READ, 8'hff, 8'h00, 8'h00);
		chk(operand, 16'h00c3);
	endtask
	// wide load, store, modify and test
	task automatic t_mem();
		ld(2'h0, 16'h0200);
		u_ims_mem_model.mem[16'h0210] = 8'h12;
		u_ims_mem_model.mem[16'h0211] = 8'h34;
		u_ims_mem_model.mem[16'h0204] = 8'h11;
		u_ims_mem_model.mem[16'h0205] = 8'h22;
		exec(GRP_WIDE_LOAD, 8'h10, 8'h00, 8'h00);
		chk(operand, 16'h1234);
		chk(n_opv, 16'h0001);
		exec(GRP_ACC_STORE, 8'h03, 8'h7e, 8'h00);
		chk(m(16'h0203), 16'h007e);
		chk(n_opv, 16'h0000);
		exec(GRP_RMW, 8'h04, 8'h00, 8'h99);
		chk(m(16'h0204), 16'h0099);
		exec(GRP_TEST, 8'h05, 8'h00, 8'h99);
		chk(m(16'h0205), 16'h0022);
	endtask
	// wide stores of stack and index pointers
	task automatic t_wst();
		ld(2'h1, 16'h0ff0);
		exec(GRP_STORE_SP, 8'h06, 8'h00, 8'h00);
		chk(m2(16'h0206), 16'h0ff0);
		exec(GRP_STORE_IX, 8'h08, 8'h00, 8'h00);
		chk(m2(16'h0208), 16'h0200);
	endtask
	// jump then subroutine call
	task automatic t_flow();
		ld(2'h0, 16'h0280);
		exec(GRP_JUMP, 8'h90, 8'h00, 8'h00);
		chk(pc, 16'h0310);
		ld(2'h0, 16'h0200);
		exec(GRP_CALL, 8'h40, 8'h00, 8'h00);
		chk(pc, 16'h0240);
		chk(sp, 16'h0fee);
		chk(m2(16'h0fef), 16'h0312);
	endtask
	// verdict and end of run
	task automatic conclude();
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// reset, then every scenario in turn
	initial begin
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		t_ptr();
		t_read();
		t_mem();
		t_wst();
		t_flow();
		conclude();
	end
	// watchdog, far beyond the fewer than two hundred cycles needed
	initial begin
		#400000;
		n_mismatch++;
		conclude();
	end
endmodule
`default_nettype wire
